// file: gate_bank_assertions.sv
/* checker for the gate bank: bus answer timing, response codes, read masks
   and gate timing. assumes the consts header and a strap static after reset. */
`timescale 1ns/1ps
`include "gate_bank_consts.vh"
module gate_bank_checker (
    input wire        CORE_CLK,
    input wire        RST_N,
    input wire [4:0]  S_AXI_AWADDR,
    input wire        S_AXI_AWVALID,
    input wire        S_AXI_AWREADY,
    input wire        S_AXI_WVALID,
    input wire        S_AXI_WREADY,
    input wire [1:0]  S_AXI_BRESP,
    input wire        S_AXI_BVALID,
    input wire [4:0]  S_AXI_ARADDR,
    input wire        S_AXI_ARVALID,
    input wire        S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire        S_AXI_RVALID,
    input wire        S_AXI_RREADY,
    input wire [30:0] UNIT_PRESENT,
    input wire [30:0] UNIT_CLK_EN,
    input wire [30:0] UNIT_REG_EN
);
    // implemented bits, register index 0 at the bottom
    localparam [111:0] MASKS = {`MASK_GATE_EIGHT, `MASK_GATE_SEVEN, `MASK_GATE_SIX, `MASK_GATE_FOUR,
                                `MASK_GATE_THREE, `MASK_GATE_TWO, `MASK_GATE_ONE};
    reg [4:0] waddr;  // last write address taken
    reg [4:0] raddr;  // last read address taken
    // remember the addresses of accepted requests
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            waddr <= 5'h00;
            raddr <= 5'h00;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) waddr <= S_AXI_AWADDR;
            if (S_AXI_ARVALID && S_AXI_ARREADY) raddr <= S_AXI_ARADDR;
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    a_twin_enables: assert property (UNIT_REG_EN == UNIT_CLK_EN)
        else $error("register enable differs from clock enable");
    a_absent_off: assert property ((UNIT_CLK_EN & ~$past(UNIT_PRESENT, 2)) == 31'h0)
        else $error("absent unit enabled");
    a_gate_delay: assert property ((UNIT_CLK_EN != $past(UNIT_CLK_EN)) && $past(RST_N, 3)
        |-> $past(S_AXI_BVALID) && !$past(S_AXI_BVALID, 2)) else $error("gate change off its cycle");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read not answered next cycle");
    a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |-> ##[1:2] S_AXI_BVALID) else $error("write not answered");
    a_resp_code: assert property (S_AXI_BVALID
        |-> S_AXI_BRESP == ((waddr[4:2] == 3'h7) ? `RESP_SLVERR : `RESP_OKAY)) else $error("bad write response");
    a_read_mask: assert property (S_AXI_RVALID && raddr[4:2] != 3'h7
        |-> (S_AXI_RDATA & ~{16'h0000, MASKS[16*raddr[4:2] +: 16]}) == 32'h0) else $error("unused bit read one");
    a_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read answer dropped or changed");
    cover property (S_AXI_BVALID && S_AXI_BRESP == `RESP_SLVERR);
    cover property (S_AXI_RVALID && !S_AXI_RREADY);
    cover property (UNIT_CLK_EN != $past(UNIT_CLK_EN));
endmodule // gate_bank_checker

bind peripheral_gate_bank gate_bank_checker gate_bank_checker_inst (.*);

// file: gate_bank_consts.vh
/*
 peripheral gate bank constants: register byte offsets, implemented bit masks,
 reset values and field positions.
 assumes inclusion by bare name from the design files.
*/
`ifndef GATE_BANK_CONSTS_VH
`define GATE_BANK_CONSTS_VH

// register byte offsets on the register bus
`define OFS_GATE_ONE         5'h00
`define OFS_GATE_TWO         5'h04
`define OFS_GATE_THREE       5'h08
`define OFS_GATE_FOUR        5'h0c
`define OFS_GATE_SIX         5'h10
`define OFS_GATE_SEVEN       5'h14
`define OFS_GATE_EIGHT       5'h18
`define OFS_PRESENT          5'h1c

// implemented bits of each register
`define MASK_GATE_ONE        16'h0ef9
`define MASK_GATE_TWO        16'h000f
`define MASK_GATE_THREE      16'h0088
`define MASK_GATE_FOUR       16'h0008
`define MASK_GATE_SIX        16'h0f00
`define MASK_GATE_SEVEN      16'h0108
`define MASK_GATE_EIGHT      16'h293e

// reset value of every gate register
`define GATE_RESET           16'h0000

// field positions, first register
`define BIT_BASIC_TIMER      11
`define BIT_ENCODER          10
`define BIT_PULSE_WIDTH      9
`define BIT_TWO_WIRE         7
`define BIT_ASYNC_B          6
`define BIT_ASYNC_A          5
`define BIT_SYNC_B           4
`define BIT_SYNC_A           3
`define BIT_CONVERTER        0
// third register
`define BIT_CHECKSUM         7
`define BIT_ASYNC_C          3
// fourth register
`define BIT_REFCLK           3
// seventh register
`define BIT_COMPARATOR       8
`define BIT_TRIGGER_GEN      3
// eighth register
`define BIT_AMPLIFIERS       13
`define BIT_NIBBLE_A         11
`define BIT_DEADMAN          8
`define BIT_BIAS             1

// number of peripheral enable outputs, one of them never gated
`define NUM_UNITS            31

// axi response codes
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// file: gate_sync_stage.v
/*
 one-cycle retiming stage for the gate outputs, so that a gate change reaches
 the peripherals one cycle after the write that made it.
 assumes the same clock and reset as the register bank.
*/
`timescale 1ns/1ps

module gate_sync_stage (
    input  wire                  clk,        // core clock
    input  wire                  rst_n,      // async reset, active low
    input  wire [30:0]           gate_in,    // gates as held in registers
    output reg  [30:0]           gate_out    // gates as seen by peripherals
);

    // register the gates; no peripheral is gated after reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_out <= 31'h00000000;
        end else begin
            gate_out <= gate_in;
        end
    end

endmodule // gate_sync_stage

// file: peripheral_gate_bank.v
/*
 peripheral gate bank: seven clock-gating control registers behind an
 axi4-lite slave, and per-unit clock enables for the gated peripherals.
 assumes a single core clock, an axi4-lite master in the same domain, and a
 present-unit strap vector that is static after reset.
*/
`timescale 1ns/1ps
`include "gate_bank_consts.vh"

// Summary of operation
// [RL1] timer, encoder, pwm gated in first register
// [RL2] serial ports and converter gated, first register
// [RL3] four capture/compare gates, second register
// [RL4] checksum and third async port gates
// [RL5] reference clock output gate, fourth register
// [RL6] four dma channel gates, sixth register
// [RL7] one bit gates all amplifiers
// [RL8] nibble link and deadman timer gates
// [RL9] logic cells and bias source gates
// [RL10] unused bits ignore writes, read zero
// [RL11] gated unit loses clock and registers
// [RL12] gate change takes effect one cycle later
// [RL13] unit runs only if present and enabled
// [RL14] all gates reset to zero
// [RL15] eighth register bit twelve reads zero
module peripheral_gate_bank (
    input  wire                  CORE_CLK,       // system clock, 20 MHz
    input  wire                  RST_N,          // async reset, active low
    input  wire [4:0]            S_AXI_AWADDR,   // write address
    input  wire                  S_AXI_AWVALID,  // write address valid
    output wire                  S_AXI_AWREADY,  // write address ready
    input  wire [31:0]           S_AXI_WDATA,    // write data
    input  wire [3:0]            S_AXI_WSTRB,    // write byte strobes
    input  wire                  S_AXI_WVALID,   // write data valid
    output wire                  S_AXI_WREADY,   // write data ready
    output reg  [1:0]            S_AXI_BRESP,    // write response
    output reg                   S_AXI_BVALID,   // write response valid
    input  wire                  S_AXI_BREADY,   // write response ready
    input  wire [4:0]            S_AXI_ARADDR,   // read address
    input  wire                  S_AXI_ARVALID,  // read address valid
    output wire                  S_AXI_ARREADY,  // read address ready
    output reg  [31:0]           S_AXI_RDATA,    // read data
    output reg  [1:0]            S_AXI_RRESP,    // read response
    output reg                   S_AXI_RVALID,   // read data valid
    input  wire                  S_AXI_RREADY,   // read data ready
    input  wire [30:0]           UNIT_PRESENT,   // strap: unit exists in variant
    output wire [30:0]           UNIT_CLK_EN,    // per-unit clock enable
    output wire [30:0]           UNIT_REG_EN     // per-unit register access enable
);

    // gate registers, unimplemented bits only ever hold zeros
    reg  [15:0]                  gate_ctrl_one;
    reg  [15:0]                  gate_ctrl_two;
    reg  [15:0]                  gate_ctrl_three;
    reg  [15:0]                  gate_ctrl_four;
    reg  [15:0]                  gate_ctrl_six;
    reg  [15:0]                  gate_ctrl_seven;
    reg  [15:0]                  gate_ctrl_eight;

    // write channel capture
    reg                          aw_held;        // write address captured
    reg  [4:0]                   aw_addr;        // captured write address
    reg                          w_held;         // write data captured
    reg  [31:0]                  w_data;         // captured write data
    reg  [3:0]                   w_strb;         // captured strobes

    // present-unit strap, resampled through two stages every cycle
    reg  [30:0]                  present_meta;   // first synchroniser stage
    reg  [30:0]                  present_sync;   // second synchroniser stage

    // gate vector in register order and after retiming
    wire [30:0]                  gate_vec;
    wire [30:0]                  gate_late;

    // write commits when both halves are in and no response is pending
    wire                         do_write;
    wire                         wr_hit;
    reg  [31:0]                  rd_word;
    reg                          rd_hit;

    // merge byte strobes into a register, keeping only implemented bits
    function [15:0] merge_bytes;
        input [15:0] old_val;
        input [31:0] new_val;
        input [3:0]  strb;
        input [15:0] mask;
        reg   [15:0] tmp;
        begin
            tmp = old_val;
            if (strb[0]) begin
                tmp[7:0] = new_val[7:0];
            end
            if (strb[1]) begin
                tmp[15:8] = new_val[15:8];
            end
            merge_bytes = tmp & mask;
        end
    endfunction

    // address decode for the write path; the read mux decodes on its own
    function is_mapped;
        input [4:0] addr;
        begin
            case (addr)
                `OFS_GATE_ONE, `OFS_GATE_TWO, `OFS_GATE_THREE,
                `OFS_GATE_FOUR, `OFS_GATE_SIX, `OFS_GATE_SEVEN,
                `OFS_GATE_EIGHT: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    // ready while the channel has nothing captured
    assign S_AXI_AWREADY = ~aw_held;
    assign S_AXI_WREADY  = ~w_held;
    assign S_AXI_ARREADY = ~S_AXI_RVALID;

    assign do_write = aw_held & w_held & ~S_AXI_BVALID;
    assign wr_hit   = is_mapped(aw_addr);

    // capture address and data in either order
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_held <= 1'b0;
            aw_addr <= 5'h00;
            w_held  <= 1'b0;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
        end else begin
            // address channel
            if (S_AXI_AWVALID && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            // data channel
            if (S_AXI_WVALID && !w_held) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // gate registers
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            // [RL14] gates clear at reset
            gate_ctrl_one   <= `GATE_RESET;
            gate_ctrl_two   <= `GATE_RESET;
            gate_ctrl_three <= `GATE_RESET;
            gate_ctrl_four  <= `GATE_RESET;
            gate_ctrl_six   <= `GATE_RESET;
            gate_ctrl_seven <= `GATE_RESET;
            gate_ctrl_eight <= `GATE_RESET;
        end else if (do_write) begin
            // [RL10] masks drop unused bits
            case (aw_addr)
                `OFS_GATE_ONE: begin
                    gate_ctrl_one <= merge_bytes(gate_ctrl_one, w_data, w_strb, `MASK_GATE_ONE);
                end
                `OFS_GATE_TWO: begin
                    gate_ctrl_two <= merge_bytes(gate_ctrl_two, w_data, w_strb, `MASK_GATE_TWO);
                end
                `OFS_GATE_THREE: begin
                    gate_ctrl_three <= merge_bytes(gate_ctrl_three, w_data, w_strb, `MASK_GATE_THREE);
                end
                `OFS_GATE_FOUR: begin
                    gate_ctrl_four <= merge_bytes(gate_ctrl_four, w_data, w_strb, `MASK_GATE_FOUR);
                end
                `OFS_GATE_SIX: begin
                    gate_ctrl_six <= merge_bytes(gate_ctrl_six, w_data, w_strb, `MASK_GATE_SIX);
                end
                `OFS_GATE_SEVEN: begin
                    gate_ctrl_seven <= merge_bytes(gate_ctrl_seven, w_data, w_strb, `MASK_GATE_SEVEN);
                end
                `OFS_GATE_EIGHT: begin
                    // [RL15] mask keeps bit twelve clear
                    gate_ctrl_eight <= merge_bytes(gate_ctrl_eight, w_data, w_strb, `MASK_GATE_EIGHT);
                end
                default: begin
                    // unmapped: nothing stored
                end
            endcase
        end
    end

    // write response
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `RESP_OKAY;
        end else if (do_write) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // read mux: stored bits, present strap, or error
    always @* begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        case (S_AXI_ARADDR)
            `OFS_GATE_ONE:   rd_word = {16'h0000, gate_ctrl_one};
            `OFS_GATE_TWO:   rd_word = {16'h0000, gate_ctrl_two};
            `OFS_GATE_THREE: rd_word = {16'h0000, gate_ctrl_three};
            `OFS_GATE_FOUR:  rd_word = {16'h0000, gate_ctrl_four};
            `OFS_GATE_SIX:   rd_word = {16'h0000, gate_ctrl_six};
            `OFS_GATE_SEVEN: rd_word = {16'h0000, gate_ctrl_seven};
            `OFS_GATE_EIGHT: rd_word = {16'h0000, gate_ctrl_eight};
            `OFS_PRESENT:    rd_word = {1'b0, present_sync};
            default:         rd_hit  = 1'b0;
        endcase
    end

    // read data channel
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h00000000;
            S_AXI_RRESP  <= `RESP_OKAY;
        end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_word;
            S_AXI_RRESP  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // strap synchroniser
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            present_meta <= 31'h00000000;
            present_sync <= 31'h00000000;
        end else begin
            present_meta <= UNIT_PRESENT;
            present_sync <= present_meta;
        end
    end

    // gate vector, one bit per unit
    // [RL1] timer, encoder, pwm
    // [RL2] serial ports, converter
    // [RL3] capture/compare d..a
    // [RL4] checksum, async c
    // [RL5] reference clock out
    // [RL6] dma channels d..a
    // [RL7] all amplifiers
    // [RL8] nibble link, deadman
    // [RL9] logic cells, bias
    assign gate_vec = {
        gate_ctrl_one[`BIT_BASIC_TIMER],     // 30 basic_timer_off
        gate_ctrl_one[`BIT_ENCODER],         // 29 encoder_unit_off
        gate_ctrl_one[`BIT_PULSE_WIDTH],     // 28 pulse_width_unit_off
        gate_ctrl_one[`BIT_TWO_WIRE],        // 27 two_wire_port_off
        gate_ctrl_one[`BIT_ASYNC_B],         // 26 async_port_b_off
        gate_ctrl_one[`BIT_ASYNC_A],         // 25 async_port_a_off
        gate_ctrl_one[`BIT_SYNC_B],          // 24 sync_port_b_off
        gate_ctrl_one[`BIT_SYNC_A],          // 23 sync_port_a_off
        gate_ctrl_one[`BIT_CONVERTER],       // 22 converter_off
        gate_ctrl_two[3:0],                  // 21..18 capcomp d..a
        gate_ctrl_three[`BIT_CHECKSUM],      // 17 checksum_unit_off
        gate_ctrl_three[`BIT_ASYNC_C],       // 16 async_port_c_off
        gate_ctrl_four[`BIT_REFCLK],         // 15 refclk_out_off
        gate_ctrl_six[11:8],                 // 14..11 dma d..a
        gate_ctrl_seven[`BIT_COMPARATOR],    // 10 comparator_a_off
        gate_ctrl_seven[`BIT_TRIGGER_GEN],   // 9 trigger_gen_off
        gate_ctrl_eight[`BIT_AMPLIFIERS],    // 8 amplifiers_off
        gate_ctrl_eight[`BIT_NIBBLE_A],      // 7 nibble_link_a_off
        gate_ctrl_eight[`BIT_DEADMAN],       // 6 deadman_timer_off
        gate_ctrl_eight[5:2],                // 5..2 logic cells d..a
        gate_ctrl_eight[`BIT_BIAS],          // 1 bias_source_off
        1'b0                                 // 0 spare, never gated
    };

    // [RL12] one-cycle retiming stage
    gate_sync_stage u_gate_sync (
        .clk      (CORE_CLK),
        .rst_n    (RST_N),
        .gate_in  (gate_vec),
        .gate_out (gate_late)
    );

    // [RL13] present and not gated
    // [RL11] gated unit loses clock and registers
    assign UNIT_CLK_EN = present_sync & ~gate_late;
    assign UNIT_REG_EN = present_sync & ~gate_late;

endmodule // peripheral_gate_bank

// file: tb_peripheral_gate_bank.sv
/* self-checking bench for the peripheral gate bank: map, masks, strobes,
   unit gating and its timing. assumes the consts header and the checker. */
`timescale 1ns/1ps
`include "gate_bank_consts.vh"
module tb_peripheral_gate_bank;
    // byte i-1 of the map: register index of unit i in [6:4], its bit in [3:0]
    localparam [239:0] MAP = 240'h0b0a090706050403_00131211102723334b4a4948_58536d6b686564636261;
    localparam [111:0] MASKS = {`MASK_GATE_EIGHT, `MASK_GATE_SEVEN, `MASK_GATE_SIX, `MASK_GATE_FOUR,
                                `MASK_GATE_THREE, `MASK_GATE_TWO, `MASK_GATE_ONE};
    reg         core_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    reg  [4:0]  awaddr, araddr;
    reg  [31:0] wdata;
    reg  [3:0]  wstrb;
    reg  [30:0] unit_present, present;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [30:0] unit_clk_en, unit_reg_en;
    reg  [15:0] shadow [0:6];  // expected register contents
    integer     errors, compares, i;
    reg  [7:0]  e;
    reg  [30:0] old;
    reg  [1:0]  resp;
    reg  [31:0] rw;     // word read back from the strap or an unmapped address

    peripheral_gate_bank peripheral_gate_bank_inst (
        .CORE_CLK(core_clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .UNIT_PRESENT(unit_present),
        .UNIT_CLK_EN(unit_clk_en), .UNIT_REG_EN(unit_reg_en));

    // verdict and end of run
    task automatic stop_test;
        begin
            if (errors == 0 && compares > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // compare one value and count it
    task automatic check(input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // no answer within the bound
    task automatic give_up;
        begin
            errors = errors + 1;
            $display("FAIL %0t: bus answer missing", $time);
            stop_test;
        end
    endtask
    // one write, address and data offered together
    task automatic wr(input [4:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
        integer n;
        begin
            @(posedge core_clk);
            awaddr <= a;
            wdata <= d;
            wstrb <= s;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            for (n = 0; n < 20; n = n + 1) begin
                @(posedge core_clk);
                if (awready) awvalid <= 1'h0;
                if (wready) wvalid <= 1'h0;
                if (bvalid) begin
                    r = bresp;
                    bready <= 1'h0;
                    n = 99;
                end
            end
            if (n == 20) give_up;
        end
    endtask
    // one read; slow holds rready back until the answer is seen
    task automatic rd(input [4:0] a, input slow, output [31:0] d);
        integer n;
        begin
            @(posedge core_clk);
            araddr <= a;
            arvalid <= 1'h1;
            rready <= !slow;
            for (n = 0; n < 20; n = n + 1) begin
                @(posedge core_clk);
                if (arready) arvalid <= 1'h0;
                if (rvalid && !rready) rready <= 1'h1;
                else if (rvalid) begin
                    d = rdata;
                    resp = rresp;
                    rready <= 1'h0;
                    n = 99;
                end
            end
            if (n == 20) give_up;
        end
    endtask
    // write a register and track its expected contents by byte lane
    task automatic put(input [2:0] r, input [31:0] d, input [3:0] s);
        reg [15:0] ln;
        begin
            ln = {{8{s[1]}}, {8{s[0]}}};
            wr({r, 2'h0}, d, s, resp);
            shadow[r] = ((shadow[r] & ~ln) | (d[15:0] & ln)) & MASKS[16*r +: 16];
        end
    endtask
    // read a register back against its expected contents
    task automatic reg_chk(input [2:0] r, input slow);
        reg [31:0] d;
        begin
            rd({r, 2'h0}, slow, d);
            check(d, {16'h0000, shadow[r]});
        end
    endtask
    // enables implied by the strap and the expected registers
    function automatic [30:0] exp_en();
        integer k;
        reg [7:0] m;
        begin
            exp_en = present;
            for (k = 1; k <= 30; k = k + 1) begin
                m = MAP[8*k-1 -: 8];
                if (shadow[m[6:4]][m[3:0]]) exp_en[k] = 1'h0;
            end
        end
    endfunction
    // reset with a given strap
    task automatic reset_bank(input [30:0] p);
        begin
            @(posedge core_clk);
            rst_n <= 1'h0;
            unit_present <= p;
            present = p;
            for (i = 0; i < 7; i = i + 1) shadow[i] = 16'h0000;
            repeat (4) @(posedge core_clk);
            rst_n <= 1'h1;
        end
    endtask

    // free-running core clock, 50 ns
    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end
    // main sequence
    initial begin
        errors = 0;
        compares = 0;
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = 46'h0;
        unit_present = 31'h7fffffff;
        reset_bank(31'h7fffffff);
        for (i = 0; i < 7; i = i + 1) reg_chk(i, 1'h0);
        @(negedge core_clk);
        check({1'h0, unit_clk_en}, {1'h0, exp_en()});
        // walk every gate bit alone
        for (i = 1; i <= 30; i = i + 1) begin
            e = MAP[8*i-1 -: 8];
            old = exp_en();
            put(e[6:4], 32'h1 << e[3:0], 4'hf);
            check({1'h0, unit_clk_en}, {1'h0, old});
            @(negedge core_clk);
            check({1'h0, unit_clk_en}, {1'h0, present & ~(31'h1 << i)});
            check({1'h0, unit_reg_en}, {1'h0, present & ~(31'h1 << i)});
            reg_chk(e[6:4], 1'h0);
            put(e[6:4], 32'h0, 4'hf);
        end
        // all ones everywhere: only implemented bits stick
        for (i = 0; i < 7; i = i + 1) begin
            put(i, 32'hffffffff, 4'hf);
            reg_chk(i, i == 6);
        end
        @(negedge core_clk);
        check({1'h0, unit_clk_en}, {1'h0, exp_en()});
        // byte lanes and a write to the read-only strap word
        put(6, 32'h0, 4'h1);
        reg_chk(6, 1'h0);
        put(0, 32'h0, 4'h2);
        reg_chk(0, 1'h0);
        wr(5'h1c, 32'hffffffff, 4'hf, resp);
        check({30'h0, resp}, {30'h0, `RESP_SLVERR});
        for (i = 0; i < 7; i = i + 1) reg_chk(i, 1'h0);
        // strap word reads back the present units, with an okay response
        rd(`OFS_PRESENT, 1'h0, rw);
        check(rw, {1'h0, present});
        check({30'h0, resp}, {30'h0, `RESP_OKAY});
        // an unaligned address is unmapped: error response and zero data
        rd(5'h01, 1'h0, rw);
        check(rw, 32'h0);
        check({30'h0, resp}, {30'h0, `RESP_SLVERR});
        // second reset with some units absent
        reset_bank(31'h2aaaaaab);
        for (i = 0; i < 7; i = i + 1) reg_chk(i, 1'h0);
        put(0, 32'h400, 4'hf);
        @(negedge core_clk);
        check({1'h0, unit_clk_en}, {1'h0, 31'h2aaaaaab & ~(31'h1 << 29)});
        stop_test;
    end
endmodule // tb_peripheral_gate_bank
